// file: core/sqm_core.sv
`timescale 1ns/1ps
// Contract
// - Slicer error is signed, magnitude at most 32.
// - Sequence routes slicer error into quality logic.
// - Quality registers live in device address 30.
// - Measure only while enable bit is set.
// - Square error, then low-pass filter it.
// - Add weighted difference back into filter state.
// - Gain shift divides difference by power two.
// - Scale by power two, saturate at 511.
// - Latch filtered value every 65536 symbols.
// - Capture bit self-clears, loads error result.
// - Keep largest error since last result read.
// - Seven thresholds map error to index 0..7.
// - Capture also loads current quality index.
// - Keep lowest index since last read.
// - Drop link only at index zero.
module sqm_core #(
  parameter int SNAP_SYMBOLS = sqm_pkg::SNAP_SYMBOLS
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_valid_i,
  input wire logic [sqm_pkg::ERR_W-1:0] slicer_error_sample_i,
  output logic test_bus_on_o,
  output logic link_drop_o
);

  localparam int CNT_W = $clog2(SNAP_SYMBOLS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SNAP_SYMBOLS - 1);

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  sqm_pkg::sqm_cfg_t cfg_reg;
  sqm_pkg::sqm_pc_state_t pc_reg;
  sqm_pkg::sqm_pc_state_t pc_next;
  logic [7:1][sqm_pkg::MSE_W-1:0] thr_reg;
  logic [15:0] test_ctl_reg;
  logic [15:0] test_wr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic [CNT_W-1:0] sym_cnt_reg;
  logic snap_valid_reg;
  logic [sqm_pkg::MSE_W-1:0] mse_snap_reg;
  logic [sqm_pkg::IDX_W-1:0] idx_snap_reg;
  logic [sqm_pkg::MSE_W-1:0] mse_result_reg;
  logic [sqm_pkg::MSE_W-1:0] mse_worst_reg;
  logic [sqm_pkg::IDX_W-1:0] idx_cur_reg;
  logic [sqm_pkg::IDX_W-1:0] idx_worst_reg;
  logic link_drop_reg;
  logic [sqm_pkg::STATE_W-1:0] filt;
  logic [sqm_pkg::IDX_W-1:0] idx_map;

  wire logic setup = psel_i && !penable_i;
  wire logic access = psel_i && penable_i;
  wire logic [4:0] dev = paddr_i[11:7];
  wire logic [4:0] idx = paddr_i[6:2];
  wire logic aligned = (paddr_i[1:0] == 2'b00);
  wire logic dev_q = aligned && (dev == sqm_pkg::DEV_QUALITY);
  wire logic dev_t = aligned && (dev == sqm_pkg::DEV_TEST);
  wire logic hit_tbl = dev_q && (idx >= sqm_pkg::IDX_TBL1) &&
                       (idx <= sqm_pkg::IDX_TBL7);
  wire logic hit_tc = dev_t && (idx == sqm_pkg::IDX_TEST_CTL);
  wire logic hit_tw = dev_t && (idx == sqm_pkg::IDX_TEST_WR);
  wire logic mapped = (dev_q && (idx <= sqm_pkg::IDX_TBL7)) ||
                      hit_tc || hit_tw;
  wire logic wr = access && pwrite_i && mapped;
  wire logic rd = access && !pwrite_i && mapped;
  wire logic wr_cfg = wr && dev_q && (idx == sqm_pkg::IDX_CFG);
  wire logic wr_tc = wr && hit_tc;
  wire logic wr_tw = wr && hit_tw;
  wire logic [15:0] wdata = pwdata_i[15:0];
  wire logic [2:0] tbl_sel = 3'(idx - sqm_pkg::IDX_TBL1 + 5'h01);
  // capture is a pulse, never stored
  wire logic capture = wr_cfg && pwdata_i[sqm_pkg::CFG_CAP_BIT];
  wire logic mse_rd = rd && dev_q && (idx == sqm_pkg::IDX_MSE);
  wire logic qidx_rd = rd && dev_q && (idx == sqm_pkg::IDX_QIDX);

  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = prdata_reg;

  // The read word is taken in the setup cycle so that prdata comes
  // from a flip-flop while the slave still answers without wait.
  always_comb begin
    rd_next = 32'h0000_0000;
    if (dev_q) begin
      unique case (idx)
        sqm_pkg::IDX_CFG: rd_next[15:0] = {5'h00, cfg_reg};
        sqm_pkg::IDX_MSE: rd_next[8:0] = mse_result_reg;
        sqm_pkg::IDX_MSE_WORST: rd_next[8:0] = mse_worst_reg;
        sqm_pkg::IDX_QIDX: begin
          rd_next[2:0] = idx_cur_reg;
          rd_next[sqm_pkg::QIDX_WORST_LSB +: 3] = idx_worst_reg;
        end
        default: begin
          if (hit_tbl) begin
            rd_next[8:0] = thr_reg[tbl_sel];
          end
        end
      endcase
    end else if (hit_tc) begin
      rd_next[15:0] = test_ctl_reg;
    end else if (hit_tw) begin
      rd_next[15:0] = test_wr_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and threshold registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_reg <= sqm_pkg::sqm_cfg_t'(sqm_pkg::CFG_RST[10:0]);
    end else if (wr_cfg) begin
      cfg_reg <= sqm_pkg::sqm_cfg_t'(wdata[10:0]);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int k = 1; k <= 7; k++) begin
        thr_reg[k] <= 9'(sqm_pkg::TBL_STEP * (8 - k));
      end
    end else if (wr && hit_tbl) begin
      thr_reg[tbl_sel] <= pwdata_i[8:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      test_ctl_reg <= sqm_pkg::TEST_RST;
      test_wr_reg <= sqm_pkg::TEST_RST;
    end else begin
      if (wr_tc) begin
        test_ctl_reg <= wdata;
      end
      if (wr_tw) begin
        test_wr_reg <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Preconditioning sequence
  // ----------------------------------------------------------------
  // A wrong value at any step restarts the sequence; an arming write
  // counts as its first step so a retry need not pass through idle.
  always_comb begin
    pc_next = pc_reg;
    if (wr_tc) begin
      pc_next = (wdata == sqm_pkg::TC_ARM) ? sqm_pkg::PC_ARM1
                                           : sqm_pkg::PC_IDLE;
      unique case (pc_reg)
        sqm_pkg::PC_ARM1: begin
          if (wdata == sqm_pkg::TC_DISARM) begin
            pc_next = sqm_pkg::PC_DISARM;
          end
        end
        sqm_pkg::PC_DISARM: begin
          if (wdata == sqm_pkg::TC_ARM) begin
            pc_next = sqm_pkg::PC_ARM2;
          end
        end
        sqm_pkg::PC_MAPPED, sqm_pkg::PC_ON: begin
          if (wdata == sqm_pkg::TC_BUS_ON) begin
            pc_next = sqm_pkg::PC_ON;
          end
        end
        sqm_pkg::PC_IDLE, sqm_pkg::PC_ARM2: begin
        end
      endcase
    end else if (wr_tw && pc_reg == sqm_pkg::PC_ARM2) begin
      pc_next = (wdata == sqm_pkg::TW_ROUTE) ? sqm_pkg::PC_MAPPED
                                             : sqm_pkg::PC_IDLE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_reg <= sqm_pkg::PC_IDLE;
    end else begin
      pc_reg <= pc_next;
    end
  end

  wire logic route_on = (pc_reg == sqm_pkg::PC_ON);
  wire logic run = cfg_reg.enable && route_on;
  assign test_bus_on_o = route_on;

  // ----------------------------------------------------------------
  // Filter, scaling and index
  // ----------------------------------------------------------------
  sqm_filter u_filter (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .cfg_i(cfg_reg),
    .run_i(run),
    .sample_valid_i(sample_valid_i),
    .sample_i(slicer_error_sample_i),
    .filt_o(filt)
  );

  // scale and saturate
  // The fraction bits are dropped first so that the scale shift acts
  // on the whole filtered value, as software sees it.
  wire logic [sqm_pkg::STATE_W-1:0] shifted =
    filt >> (sqm_pkg::FRAC_W + cfg_reg.scale);
  wire logic over = |shifted[sqm_pkg::STATE_W-1:sqm_pkg::MSE_W];
  wire logic [sqm_pkg::MSE_W-1:0] mse_scaled =
    over ? sqm_pkg::MSE_MAX : shifted[sqm_pkg::MSE_W-1:0];

  sqm_index_map u_index_map (
    .mse_i(mse_scaled),
    .thr_i(thr_reg),
    .idx_o(idx_map)
  );

  // ----------------------------------------------------------------
  // Snapshot interval
  // ----------------------------------------------------------------
  // symbol interval count
  wire logic snap = run && sample_valid_i && (sym_cnt_reg == CNT_LAST);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sym_cnt_reg <= '0;
    end else if (!run) begin
      sym_cnt_reg <= '0;
    end else if (sample_valid_i) begin
      sym_cnt_reg <= snap ? '0 : CNT_W'(sym_cnt_reg + 1'b1);
    end
  end

  // Snapshots survive a pause in measurement so software can still
  // read the last figure after clearing the enable bit.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snap_valid_reg <= 1'b0;
      mse_snap_reg <= '0;
      idx_snap_reg <= sqm_pkg::IDX_BEST;
    end else if (snap) begin
      snap_valid_reg <= 1'b1;
      mse_snap_reg <= mse_scaled;
      idx_snap_reg <= idx_map;
    end
  end

  // ----------------------------------------------------------------
  // Results and worst-case trackers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mse_result_reg <= '0;
      idx_cur_reg <= sqm_pkg::IDX_BEST;
    end else if (capture) begin
      mse_result_reg <= mse_snap_reg;
      idx_cur_reg <= idx_snap_reg;
    end
  end

  // A new snapshot in the cycle of a read is kept: the set wins.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mse_worst_reg <= '0;
    end else if (snap) begin
      if (mse_rd || !snap_valid_reg || mse_scaled > mse_worst_reg) begin
        mse_worst_reg <= mse_scaled;
      end
    end else if (mse_rd) begin
      mse_worst_reg <= mse_snap_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_worst_reg <= sqm_pkg::IDX_BEST;
    end else if (snap) begin
      if (qidx_rd || !snap_valid_reg || idx_map < idx_worst_reg) begin
        idx_worst_reg <= idx_map;
      end
    end else if (qidx_rd) begin
      idx_worst_reg <= idx_snap_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_drop_reg <= 1'b0;
    end else begin
      link_drop_reg <= run && snap_valid_reg &&
                       (idx_snap_reg == sqm_pkg::IDX_DROP);
    end
  end

  assign link_drop_o = link_drop_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_capture_mse_load: assert property (
    capture |=> mse_result_reg == $past(mse_snap_reg))
    else $error("capture did not load error result");

  chk_capture_idx_load: assert property (
    capture |=> idx_cur_reg == $past(idx_snap_reg))
    else $error("capture did not load quality index");

  chk_mse_saturate: assert property (
    over |-> mse_scaled == sqm_pkg::MSE_MAX)
    else $error("scaled error not saturated");

  chk_snap_gated: assert property (
    snap |-> cfg_reg.enable && $past(run))
    else $error("snapshot taken while disabled");

  chk_route_gate: assert property (
    !route_on |=> !snap_valid_reg || $stable(mse_snap_reg))
    else $error("snapshot changed without routed error");

  chk_snap_period: assert property (
    snap |=> sym_cnt_reg == '0 ##1 !snap)
    else $error("snapshot interval wrong");

  chk_mse_worst_max: assert property (
    snap && !mse_rd |=> mse_worst_reg >= mse_snap_reg)
    else $error("error worst case below snapshot");

  chk_idx_worst_min: assert property (
    snap && !qidx_rd |=> idx_worst_reg <= idx_snap_reg)
    else $error("index worst case above snapshot");

  chk_worst_restart: assert property (
    mse_rd && !snap |=> mse_worst_reg == $past(mse_snap_reg))
    else $error("worst case not restarted on read");

  chk_link_drop_zero: assert property (
    link_drop_o |-> $past(idx_snap_reg) == sqm_pkg::IDX_DROP)
    else $error("link dropped at nonzero index");

  chk_idx_best: assert property (
    mse_scaled <= thr_reg[7] |-> idx_map == sqm_pkg::IDX_BEST)
    else $error("low error not mapped to best index");

endmodule

// file: core/sqm_filter.sv
`timescale 1ns/1ps
module sqm_filter (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire sqm_pkg::sqm_cfg_t cfg_i,
  input wire logic run_i,
  input wire logic sample_valid_i,
  input wire logic [sqm_pkg::ERR_W-1:0] sample_i,
  output logic [sqm_pkg::STATE_W-1:0] filt_o
);

  // ----------------------------------------------------------------
  // Error term
  // ----------------------------------------------------------------
  logic [sqm_pkg::STATE_W-1:0] state_reg;
  logic [sqm_pkg::STATE_W-1:0] state_next;
  wire logic [6:0] err_ext = {sample_i[5], sample_i};
  wire logic [6:0] mag = sample_i[5] ? 7'(-err_ext) : err_ext;
  wire logic [6:0] mag_c = (mag > sqm_pkg::ERR_MAX) ? sqm_pkg::ERR_MAX : mag;
  wire logic [13:0] sq = mag_c * mag_c;
  wire logic [sqm_pkg::SQ_W-1:0] term =
    cfg_i.square ? sq[sqm_pkg::SQ_W-1:0] : sqm_pkg::SQ_W'(mag_c);

  // ----------------------------------------------------------------
  // First-order low-pass
  // ----------------------------------------------------------------
  wire logic signed [sqm_pkg::STATE_W:0] target =
    $signed({1'b0, term, {sqm_pkg::FRAC_W{1'b0}}});
  wire logic signed [sqm_pkg::STATE_W:0] cur = $signed({1'b0, state_reg});
  wire logic signed [sqm_pkg::STATE_W:0] diff = target - cur;
  wire logic signed [sqm_pkg::STATE_W:0] step = diff >>> cfg_i.kp;
  wire logic signed [sqm_pkg::STATE_W:0] sum = cur + step;

  assign state_next = sum[sqm_pkg::STATE_W-1:0];
  assign filt_o = state_reg;

  // The state restarts from zero whenever measurement is stopped.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else if (!run_i) begin
      state_reg <= '0;
    end else if (sample_valid_i) begin
      state_reg <= state_next;
    end
  end

  chk_clamp_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mag_c <= sqm_pkg::ERR_MAX) else $error("clamped error above limit");

  chk_filter_step: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    run_i && sample_valid_i && cfg_i.kp == '0 |=>
    state_reg == $past(target[sqm_pkg::STATE_W-1:0]))
    else $error("zero gain shift did not track input");

endmodule

// file: core/sqm_index_map.sv
`timescale 1ns/1ps
module sqm_index_map (
  input wire logic [sqm_pkg::MSE_W-1:0] mse_i,
  input wire logic [7:1][sqm_pkg::MSE_W-1:0] thr_i,
  output logic [sqm_pkg::IDX_W-1:0] idx_o
);

  // Walking from threshold seven up to one makes threshold one win,
  // so a table that is not monotonic still gives a defined index.
  function automatic logic [sqm_pkg::IDX_W-1:0] map_index(
    input logic [sqm_pkg::MSE_W-1:0] mse,
    input logic [7:1][sqm_pkg::MSE_W-1:0] thr
  );
    logic [sqm_pkg::IDX_W-1:0] idx;
    idx = sqm_pkg::IDX_BEST;
    for (int k = 7; k >= 1; k--) begin
      if (mse > thr[k]) begin
        idx = sqm_pkg::IDX_W'(k - 1);
      end
    end
    return idx;
  endfunction

  assign idx_o = map_index(mse_i, thr_i);

endmodule

// file: core/sqm_pkg.sv
package sqm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Byte address is {device[4:0], index[4:0], 2'b00}.
  localparam logic [4:0] DEV_QUALITY = 5'h1E;
  localparam logic [4:0] DEV_TEST = 5'h00;
  localparam logic [4:0] IDX_CFG = 5'h00;
  localparam logic [4:0] IDX_MSE = 5'h01;
  localparam logic [4:0] IDX_MSE_WORST = 5'h02;
  localparam logic [4:0] IDX_QIDX = 5'h03;
  localparam logic [4:0] IDX_TBL1 = 5'h04;
  localparam logic [4:0] IDX_TBL7 = 5'h0A;
  localparam logic [4:0] IDX_TEST_CTL = 5'h14;
  localparam logic [4:0] IDX_TEST_WR = 5'h17;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int KP_W = 4;
  localparam int SCALE_W = 5;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SQU_BIT = 1;
  localparam int CFG_KP_LSB = 2;
  localparam int CFG_SCALE_LSB = 6;
  localparam int CFG_CAP_BIT = 15;
  localparam int QIDX_WORST_LSB = 4;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] TEST_RST = 16'h0000;

  // Preconditioning values for the test control and test write words.
  localparam logic [15:0] TC_ARM = 16'h0400;
  localparam logic [15:0] TC_DISARM = 16'h0000;
  localparam logic [15:0] TW_ROUTE = 16'h7200;
  localparam logic [15:0] TC_BUS_ON = 16'h4401;

  // ----------------------------------------------------------------
  // Datapath widths and limits
  // ----------------------------------------------------------------
  localparam int ERR_W = 6;
  localparam logic [6:0] ERR_MAX = 7'h20;
  localparam int SQ_W = 11;
  localparam int FRAC_W = 15;
  localparam int STATE_W = SQ_W + FRAC_W;
  localparam int MSE_W = 9;
  localparam logic [8:0] MSE_MAX = 9'h1FF;
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_BEST = 3'h7;
  localparam logic [2:0] IDX_DROP = 3'h0;
  // Threshold k resets to TBL_STEP * (8 - k).
  localparam logic [8:0] TBL_STEP = 9'h040;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYMBOL_NS = 8;
  localparam int SNAPSHOT_NS = 524288;
  localparam int SNAP_SYMBOLS = SNAPSHOT_NS / SYMBOL_NS;

  typedef struct packed {
    logic [SCALE_W-1:0] scale;
    logic [KP_W-1:0] kp;
    logic square;
    logic enable;
  } sqm_cfg_t;

  typedef enum logic [2:0] {
    PC_IDLE,
    PC_ARM1,
    PC_DISARM,
    PC_ARM2,
    PC_MAPPED,
    PC_ON
  } sqm_pc_state_t;

endpackage

// file: dv/signal_quality_monitor_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, sn) \
  begin \
    checks_done++; \
    if ((sn) !== (ex)) begin \
      error_cnt++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, sn); \
    end \
  end
module signal_quality_monitor_bench;
  typedef struct packed {
    logic [5:0] e;
    logic [15:0] cfg;
    logic [4:0] n;
    logic [8:0] mse;
    logic [2:0] idx;
  } sqm_row_t;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic svalid, bus_on, link_drop, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] serr;
  int error_cnt, checks_done, cyc;
  // Default thresholds are 64 * (8 - k); each row starts from a clean filter.
  sqm_row_t rows [12] = '{
    '{6'h08, 16'h0003, 5'h08, 9'h040, 3'h7},
    '{6'h09, 16'h0003, 5'h08, 9'h051, 3'h6},
    '{6'h0C, 16'h0003, 5'h08, 9'h090, 3'h5},
    '{6'h10, 16'h0003, 5'h08, 9'h100, 3'h4},
    '{6'h11, 16'h0003, 5'h08, 9'h121, 3'h3},
    '{6'h13, 16'h0003, 5'h08, 9'h169, 3'h2},
    '{6'h2B, 16'h0003, 5'h08, 9'h1B9, 3'h1},
    '{6'h16, 16'h0003, 5'h08, 9'h1E4, 3'h0},
    '{6'h20, 16'h0003, 5'h08, 9'h1FF, 3'h0},
    '{6'h3B, 16'h0043, 5'h08, 9'h00C, 3'h7},
    '{6'h20, 16'h0087, 5'h10, 9'h0FF, 3'h4},
    '{6'h2C, 16'h0001, 5'h08, 9'h014, 3'h7}
  };

  sqm_core #(
    .SNAP_SYMBOLS(8)
  ) i_sqm_core (
    .clock_i(clk),
    .rst_b_i(rst_b),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .sample_valid_i(svalid),
    .slicer_error_sample_i(serr),
    .test_bus_on_o(bus_on),
    .link_drop_o(link_drop)
  );

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and sample drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Disabling first clears the filter and restarts the snapshot count.
  task automatic measure(input logic [5:0] e, input logic [15:0] cfg,
                         input int n);
    wr(12'hF00, 16'h0000);
    wr(12'hF00, cfg);
    repeat (n) begin
      svalid <= 1'b1;
      serr <= e;
      @(posedge clk);
    end
    svalid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, svalid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    serr = 6'h00;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdr(12'hF00);
    `CHK("cfg", 32'h0000_0000, rd)
    rdr(12'hF0C);
    `CHK("index", 7'h77, rd[6:0])
    rdr(12'hF10);
    `CHK("thr1", 9'h1C0, rd[8:0])
    rdr(12'hF28);
    `CHK("thr7", 9'h040, rd[8:0])
    rdr(12'hF7C);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rd)
    wr(12'h050, 16'h0400);
    wr(12'h050, 16'h4401);
    #1;
    `CHK("bus on early", 1'b0, bus_on)
    wr(12'h050, 16'h0400);
    wr(12'h050, 16'h0000);
    wr(12'h050, 16'h0400);
    wr(12'h05C, 16'h7200);
    wr(12'h050, 16'h4401);
    @(posedge clk);
    #1;
    `CHK("bus on", 1'b1, bus_on)
    $display("test precondition done");
    for (int i = 0; i < 12; i++) begin
      measure(rows[i].e, rows[i].cfg, rows[i].n);
      `CHK("drop", rows[i].idx == 3'h0, link_drop)
      wr(12'hF00, rows[i].cfg | 16'h8000);
      rdr(12'hF04);
      `CHK("mse", rows[i].mse, rd[8:0])
      rdr(12'hF0C);
      `CHK("index", rows[i].idx, rd[2:0])
    end
    $display("test rows done");
    measure(6'h20, 16'h0003, 8);
    wr(12'hF00, 16'h8003);
    rdr(12'hF04);
    `CHK("mse sat", 9'h1FF, rd[8:0])
    rdr(12'hF0C);
    `CHK("index low", 7'h00, rd[6:0])
    rdr(12'hF00);
    `CHK("cap clear", 32'h0000_0003, rd)
    measure(6'h04, 16'h0003, 8);
    wr(12'hF00, 16'h8003);
    rdr(12'hF08);
    `CHK("mse worst", 9'h1FF, rd[8:0])
    rdr(12'hF04);
    `CHK("mse", 9'h010, rd[8:0])
    rdr(12'hF08);
    `CHK("mse worst new", 9'h010, rd[8:0])
    rdr(12'hF0C);
    `CHK("index worst", 7'h07, rd[6:0])
    rdr(12'hF0C);
    `CHK("index worst new", 7'h77, rd[6:0])
    $display("test worst done");
    measure(6'h20, 16'h0002, 8);
    `CHK("drop off", 1'b0, link_drop)
    wr(12'hF00, 16'h8002);
    rdr(12'hF04);
    `CHK("mse idle", 9'h010, rd[8:0])
    rdr(12'hF00);
    `CHK("cap clear", 32'h0000_0002, rd)
    wr(12'hF28, 16'h000B);
    rdr(12'hF28);
    `CHK("thr7 rw", 9'h00B, rd[8:0])
    measure(6'h3B, 16'h0043, 8);
    wr(12'hF00, 16'h8043);
    rdr(12'hF0C);
    `CHK("index thr", 3'h6, rd[2:0])
    $display("test disable done");
    measure(6'h20, 16'h0003, 8);
    `CHK("drop", 1'b1, link_drop)
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset bus", 1'b0, bus_on)
    `CHK("reset drop", 1'b0, link_drop)
    rst_b <= 1'b1;
    @(posedge clk);
    rdr(12'hF0C);
    `CHK("reset index", 7'h77, rd[6:0])
    $display("test reset done");
    test_done;
  end
endmodule
